// ==== core/fim_regs.svh ====
// Purpose: Register offsets, field positions and reset values of the flash interrupt block
// Assumes: Byte addresses on a 32-bit register port
// Notes: Definitions only
`ifndef FIM_REGS_SVH
`define FIM_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define FIM_ADDR_W 12
`define FIM_OFF_RAW 12'h00c
`define FIM_OFF_EN 12'h010
`define FIM_OFF_MIS 12'h014

// ****************************************
// Field positions
// ****************************************
`define FIM_BIT_ACC 0
`define FIM_BIT_PRG 1
`define FIM_NUM_EVT 2

// ****************************************
// Reset values
// ****************************************
`define FIM_EN_RESET 2'h0
`define FIM_RAW_RESET 1'h0
`define FIM_RSYNC_RESET 1'h0

`endif

// ==== core/fim_pkg.sv ====
// Purpose: Types shared by the flash interrupt block
// Assumes: Two event sources
// Notes: Numbers live in fim_regs.svh
package fim_pkg;
  typedef logic [31:0] fim_word_t;
  typedef logic [1:0] fim_evt_t;
endpackage : fim_pkg

// ==== core/fim_bit_if.sv ====
// Purpose: Set, clear and state of one sticky event bit
// Assumes: One clock domain
// Notes: Owner holds the flop, user drives set and clear
`timescale 1ns/1ps
`default_nettype none
interface fim_bit_if;
  logic set;
  logic clr;
  logic q;
  modport owner (input set, input clr, output q);
  modport user (output set, output clr, input q);
endinterface : fim_bit_if
`default_nettype wire

// ==== core/fim_sticky_bit.sv ====
// Purpose: Sticky event bit where a set beats a simultaneous clear
// Assumes: Synchronised active-low reset
// Notes: Used once per event source
`timescale 1ns/1ps
`default_nettype none
`include "fim_regs.svh"
module fim_sticky_bit
  import fim_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  fim_bit_if.owner b
);
  logic q;
  logic next_q;

  assign next_q = b.set | (q & ~b.clr);
  assign b.q = q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= `FIM_RAW_RESET;
    end else begin
      q <= next_q;
    end
  end
endmodule : fim_sticky_bit
`default_nettype wire

// ==== core/fim_rst_sync.sv ====
// Purpose: Asynchronous assert, synchronous release of the reset
// Assumes: resetn active low
// Notes: Two flops; only the second one is read outside
`timescale 1ns/1ps
`default_nettype none
`include "fim_regs.svh"
module fim_rst_sync
  import fim_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  output logic rst_n
);
  logic stage1;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stage1 <= `FIM_RSYNC_RESET;
      rst_n <= `FIM_RSYNC_RESET;
    end else begin
      stage1 <= 1'h1;
      rst_n <= stage1;
    end
  end
endmodule : fim_rst_sync
`default_nettype wire

// ==== core/fim_flash_irq.sv ====
// Purpose: Interrupt enable, raw and masked status of a flash controller
// Assumes: Event inputs are one-cycle pulses synchronous to clk_sys
// Notes: Register port with read data one cycle after the read strobe
//
// Notes on behaviour
// RULE_01 - Program-done event reaches the interrupt only while its enable bit is set.
// RULE_02 - Access-fault event reaches the interrupt only while its enable bit is set.
// RULE_03 - Enables and masked status reset to zero; upper bits read zero, ignore writes.
// RULE_04 - Program-done masked bit is raw completion AND its enable bit.
// RULE_05 - Writing one to program-done masked bit also clears its raw bit.
// RULE_06 - Access-fault masked bit is raw fault AND its enable bit.
// RULE_07 - Writing one to access-fault masked bit also clears its raw bit.
// RULE_08 - Raw program-done bit sets when a write or erase cycle completes.
// RULE_09 - Raw access-fault bit sets on an access against the protection policy.
// RULE_10 - Interrupt output is OR of masked bits; writing zero does nothing.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fim_regs.svh"
module fim_flash_irq
  import fim_pkg::*;
#(
  parameter int ADDR_W = `FIM_ADDR_W
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic program_done_evt,
  input wire logic access_fault_evt,
  output logic flash_irq
);

  // ****************************************
  // Parameter check
  // ****************************************
  if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 5 and 32");
  end

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_n;

  fim_rst_sync u_rst_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .rst_n(rst_n)
  );

  // ****************************************
  // Address decode
  // ****************************************
  logic sel_raw;
  logic sel_en;
  logic sel_mis;
  logic wr_en;
  logic wr_mis;

  assign sel_raw = reg_addr == ADDR_W'(`FIM_OFF_RAW);
  assign sel_en = reg_addr == ADDR_W'(`FIM_OFF_EN);
  assign sel_mis = reg_addr == ADDR_W'(`FIM_OFF_MIS);
  assign wr_en = reg_wr & sel_en;
  assign wr_mis = reg_wr & sel_mis;

  // ****************************************
  // Event sources
  // ****************************************
  fim_evt_t evt;
  fim_evt_t raw;
  fim_evt_t clr_req;
  fim_evt_t wdata_lo;

  assign wdata_lo = reg_wdata[1:0];
  // Completion of a write or erase cycle from the programming engine
  assign evt[`FIM_BIT_PRG] = program_done_evt; // RULE_08
  // Protection violation flagged by the access checker
  assign evt[`FIM_BIT_ACC] = access_fault_evt; // RULE_09
  // A one clears, a zero leaves the bit alone
  assign clr_req = wr_mis ? wdata_lo : 2'h0; // RULE_05 RULE_07 RULE_10

  // ****************************************
  // Raw status bits
  // ****************************************
  fim_bit_if bit_if [`FIM_NUM_EVT] ();

  for (genvar i = 0; i < `FIM_NUM_EVT; i++) begin : g_raw
    assign bit_if[i].set = evt[i];
    assign bit_if[i].clr = clr_req[i];
    assign raw[i] = bit_if[i].q;

    fim_sticky_bit u_bit (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .b(bit_if[i])
    );
  end

  // ****************************************
  // Enable register
  // ****************************************
  fim_evt_t en;
  fim_evt_t next_en;

  // Only the two low bits are stored
  assign next_en = wr_en ? wdata_lo : en; // RULE_03

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      en <= `FIM_EN_RESET; // RULE_03
    end else begin
      en <= next_en;
    end
  end

  // ****************************************
  // Masked status and interrupt
  // ****************************************
  fim_evt_t masked;
  logic next_irq;

  assign masked[`FIM_BIT_PRG] = raw[`FIM_BIT_PRG] & en[`FIM_BIT_PRG]; // RULE_01 RULE_04
  assign masked[`FIM_BIT_ACC] = raw[`FIM_BIT_ACC] & en[`FIM_BIT_ACC]; // RULE_02 RULE_06
  assign next_irq = |masked; // RULE_10

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flash_irq <= 1'h0;
    end else begin
      flash_irq <= next_irq;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  fim_word_t rd_mux;
  fim_word_t next_rdata;

  // Reserved bits and unmapped addresses read as zero
  assign rd_mux = sel_raw ? {30'h0, raw} :
                  sel_en ? {30'h0, en} :
                  sel_mis ? {30'h0, masked} : 32'h0; // RULE_03
  assign next_rdata = reg_rd ? rd_mux : 32'h0;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_prog_fire;
    program_done_evt && en[`FIM_BIT_PRG] && !reg_wr;
  endsequence

  sequence s_acc_fire;
    access_fault_evt && en[`FIM_BIT_ACC] && !reg_wr;
  endsequence

  sequence s_quiet;
    !reg_wr;
  endsequence

  sequence s_prog_clear;
    wr_mis && reg_wdata[`FIM_BIT_PRG] && !program_done_evt;
  endsequence

  sequence s_acc_clear;
    wr_mis && reg_wdata[`FIM_BIT_ACC] && !access_fault_evt;
  endsequence

  sequence s_prog_collide;
    program_done_evt && wr_mis && reg_wdata[`FIM_BIT_PRG];
  endsequence

  sequence s_acc_collide;
    access_fault_evt && wr_mis && reg_wdata[`FIM_BIT_ACC];
  endsequence

  sequence s_prog_masked_off;
    program_done_evt && en == 2'h0 && !wr_en;
  endsequence

  sequence s_acc_masked_off;
    access_fault_evt && en == 2'h0 && !wr_en;
  endsequence

  sequence s_raw_write;
    reg_wr && sel_raw && !program_done_evt && !access_fault_evt;
  endsequence

  sequence s_clear_both;
    wr_mis && reg_wdata[1:0] == 2'h3 && !program_done_evt && !access_fault_evt;
  endsequence

  a_prog_forward: assert property ( // RULE_01
    s_prog_fire ##1 s_quiet |=> flash_irq
  ) else $error("program-done event did not raise the interrupt");

  a_acc_forward: assert property ( // RULE_02
    s_acc_fire ##1 s_quiet |=> flash_irq
  ) else $error("access-fault event did not raise the interrupt");

  a_irq_needs_enable: assert property ( // RULE_01
    flash_irq |-> ($past(en) & $past(raw)) != 2'h0
  ) else $error("interrupt high without an enabled raw bit");

  a_prog_record: assert property ( // RULE_08
    program_done_evt |=> raw[`FIM_BIT_PRG]
  ) else $error("program-done event not recorded");

  a_acc_record: assert property ( // RULE_09
    access_fault_evt |=> raw[`FIM_BIT_ACC]
  ) else $error("access-fault event not recorded");

  a_prog_w1c: assert property ( // RULE_05
    s_prog_clear |=> !raw[`FIM_BIT_PRG] && !masked[`FIM_BIT_PRG]
  ) else $error("write of one did not clear program-done status");

  a_acc_w1c: assert property ( // RULE_07
    s_acc_clear |=> !raw[`FIM_BIT_ACC] && !masked[`FIM_BIT_ACC]
  ) else $error("write of one did not clear access-fault status");

  a_zero_write_keeps: assert property ( // RULE_10
    wr_mis && !reg_wdata[`FIM_BIT_PRG] && raw[`FIM_BIT_PRG] |=> raw[`FIM_BIT_PRG]
  ) else $error("write of zero disturbed program-done status");

  a_masked_read: assert property ( // RULE_04
    reg_rd && sel_mis |=> reg_rdata == {30'h0, $past(masked)}
  ) else $error("masked status read back wrong");

  a_acc_masked_off: assert property ( // RULE_06
    !en[`FIM_BIT_ACC] |-> !masked[`FIM_BIT_ACC]
  ) else $error("access-fault masked bit set while disabled");

  a_enable_write: assert property ( // RULE_03
    wr_en |=> en == $past(wdata_lo) ##1 ($past(wr_en) || en == $past(en))
  ) else $error("enable register did not take or hold the write");

  a_rdata_window: assert property ( // RULE_03
    !reg_rd |=> reg_rdata == 32'h0
  ) else $error("read data outside the answer cycle");

  a_reset_clear: assert property ( // RULE_03
    $rose(rst_n) |-> en == 2'h0 && raw == 2'h0 && !flash_irq
  ) else $error("state not zero after reset release");

  // ****************************************
  // Recording and clearing
  // ****************************************

  a_prog_collide: assert property ( // RULE_08
    s_prog_collide |=> raw[`FIM_BIT_PRG]
  ) else $error("clear beat a program-done event in the same cycle");

  a_acc_collide: assert property ( // RULE_09
    s_acc_collide |=> raw[`FIM_BIT_ACC]
  ) else $error("clear beat an access-fault event in the same cycle");

  a_prog_sticky: assert property ( // RULE_05
    raw[`FIM_BIT_PRG] && !(wr_mis && reg_wdata[`FIM_BIT_PRG]) |=> raw[`FIM_BIT_PRG]
  ) else $error("program-done status dropped without a clear");

  a_acc_sticky: assert property ( // RULE_07
    raw[`FIM_BIT_ACC] && !(wr_mis && reg_wdata[`FIM_BIT_ACC]) |=> raw[`FIM_BIT_ACC]
  ) else $error("access-fault status dropped without a clear");

  a_acc_zero_keeps: assert property ( // RULE_10
    wr_mis && !reg_wdata[`FIM_BIT_ACC] && raw[`FIM_BIT_ACC] |=> raw[`FIM_BIT_ACC]
  ) else $error("write of zero disturbed access-fault status");

  a_prog_no_spurious: assert property ( // RULE_08
    !program_done_evt && !raw[`FIM_BIT_PRG] |=> !raw[`FIM_BIT_PRG]
  ) else $error("program-done status set without an event");

  a_acc_no_spurious: assert property ( // RULE_09
    !access_fault_evt && !raw[`FIM_BIT_ACC] |=> !raw[`FIM_BIT_ACC]
  ) else $error("access-fault status set without an event");

  a_enable_keeps_raw: assert property ( // RULE_01
    wr_en && !program_done_evt && !access_fault_evt |=> raw == $past(raw)
  ) else $error("enable write disturbed the raw status");

  // ****************************************
  // Forwarding
  // ****************************************

  a_prog_masked_off: assert property ( // RULE_04
    !en[`FIM_BIT_PRG] |-> !masked[`FIM_BIT_PRG]
  ) else $error("program-done masked bit set while disabled");

  a_prog_masked_on: assert property ( // RULE_04
    en[`FIM_BIT_PRG] && raw[`FIM_BIT_PRG] |-> masked[`FIM_BIT_PRG]
  ) else $error("program-done masked bit missing while enabled");

  a_acc_masked_on: assert property ( // RULE_06
    en[`FIM_BIT_ACC] && raw[`FIM_BIT_ACC] |-> masked[`FIM_BIT_ACC]
  ) else $error("access-fault masked bit missing while enabled");

  a_irq_follows: assert property ( // RULE_10
    1'b1 |=> flash_irq == ($past(masked) != 2'h0)
  ) else $error("interrupt does not follow the masked status");

  a_prog_suppressed: assert property ( // RULE_01
    s_prog_masked_off |=> ##1 !flash_irq
  ) else $error("disabled program-done event reached the interrupt");

  a_acc_suppressed: assert property ( // RULE_02
    s_acc_masked_off |=> ##1 !flash_irq
  ) else $error("disabled access-fault event reached the interrupt");

  a_irq_clear: assert property ( // RULE_10
    s_clear_both |=> ##1 !flash_irq
  ) else $error("interrupt stayed high after both bits were cleared");

  // ****************************************
  // Register port
  // ****************************************

  a_raw_read_only: assert property ( // RULE_03
    s_raw_write |=> raw == $past(raw)
  ) else $error("write to the raw status changed it");

  a_rdata_upper: assert property ( // RULE_03
    reg_rdata[31:2] == 30'h0
  ) else $error("reserved read data bits not zero");

  a_raw_read: assert property ( // RULE_08
    reg_rd && sel_raw |=> reg_rdata == {30'h0, $past(raw)}
  ) else $error("raw status read back wrong");

  a_enable_read: assert property ( // RULE_03
    reg_rd && sel_en |=> reg_rdata == {30'h0, $past(en)}
  ) else $error("enable register read back wrong");

  a_mis_keeps_enable: assert property ( // RULE_10
    wr_mis |=> en == $past(en)
  ) else $error("status clear disturbed the enable register");

endmodule : fim_flash_irq
`default_nettype wire

// ==== verification/fim_irq_sink.sv ====
// Purpose: Model of the processor interrupt controller that takes the flash interrupt
// Assumes: Level-sensitive interrupt input sampled on clk_sys
// Notes: Counts interrupt entries so the bench can see every rising request
`timescale 1ns/1ps
`default_nettype none
module fim_irq_sink
  import fim_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic flash_irq,
  output logic irq_pending,
  output logic [7:0] irq_entries
);
  // ****************************************
  // Level capture and entry count
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_pending <= 1'b0;
      irq_entries <= 8'h00;
    end else begin
      irq_pending <= flash_irq;
      if (flash_irq && !irq_pending) begin
        irq_entries <= irq_entries + 8'h01;
      end
    end
  end
endmodule : fim_irq_sink
`default_nettype wire

// ==== verification/tb_top.sv ====
// Purpose: Self-checking bench of the flash interrupt block
// Assumes: Register port with read data in the cycle after the strobe
// Notes: Scenarios run in order after one reset; the last scenario, t_mid_reset, resets the block again
`timescale 1ns/1ps
`default_nettype none
`include "fim_regs.svh"
module tb_top;
  import fim_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  fim_word_t reg_wdata = 32'h0;
  fim_word_t reg_rdata;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic program_done_evt = 1'b0;
  logic access_fault_evt = 1'b0;
  logic flash_irq;
  logic irq_pending;
  logic [7:0] irq_entries;
  int error_cnt = 0;
  int n_compared = 0;

  always #5 clk_sys = ~clk_sys;

  fim_flash_irq #(.ADDR_W(12)) u_fim_flash_irq (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .program_done_evt(program_done_evt), .access_fault_evt(access_fault_evt), .flash_irq(flash_irq));
  fim_irq_sink u_fim_irq_sink (.clk_sys(clk_sys), .resetn(resetn), .flash_irq(flash_irq),
    .irq_pending(irq_pending), .irq_entries(irq_entries));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic close_out;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string name, input fim_word_t exp, input fim_word_t got);
    n_compared++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input fim_word_t d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input string name, input logic [11:0] a, input fim_word_t exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(name, exp, reg_rdata);
  endtask : rd_chk

  task automatic pulse(input logic [1:0] which);
    @(posedge clk_sys);
    program_done_evt <= which[1];
    access_fault_evt <= which[0];
    @(posedge clk_sys);
    program_done_evt <= 1'b0;
    access_fault_evt <= 1'b0;
  endtask : pulse

  task automatic wait_irq(input logic exp);
    int i;
    for (i = 0; i < 8 && irq_pending !== exp; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("irq_pending", {31'h0, exp}, {31'h0, irq_pending});
    if (irq_pending !== exp) begin
      close_out();
    end
  endtask : wait_irq

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_and_reserved;
    rd_chk("enable", `FIM_OFF_EN, 32'h0);
    rd_chk("masked", `FIM_OFF_MIS, 32'h0);
    rd_chk("raw", `FIM_OFF_RAW, 32'h0);
    chk("flash_irq", 32'h0, {31'h0, flash_irq});
    wr(`FIM_OFF_EN, 32'hffff_fffc);
    rd_chk("enable_upper", `FIM_OFF_EN, 32'h0);
    wr(`FIM_OFF_MIS, 32'hffff_ffff);
    rd_chk("masked_upper", `FIM_OFF_MIS, 32'h0);
    wr(`FIM_OFF_RAW, 32'h3);
    rd_chk("raw_read_only", `FIM_OFF_RAW, 32'h0);
    rd_chk("unmapped", 12'h018, 32'h0);
  endtask : t_reset_and_reserved

  task automatic t_single_event(input int idx);
    fim_word_t m;
    m = 32'h1 << idx;
    pulse(m[1:0]);
    rd_chk("raw_set", `FIM_OFF_RAW, m);
    rd_chk("masked_off", `FIM_OFF_MIS, 32'h0);
    repeat (4) @(posedge clk_sys);
    #1;
    chk("irq_masked", 32'h0, {31'h0, flash_irq});
    wr(`FIM_OFF_EN, m);
    rd_chk("masked_on", `FIM_OFF_MIS, m);
    wait_irq(1'b1);
    wr(`FIM_OFF_MIS, 32'h0);
    rd_chk("write_zero", `FIM_OFF_MIS, m);
    wr(`FIM_OFF_MIS, m);
    rd_chk("raw_cleared", `FIM_OFF_RAW, 32'h0);
    rd_chk("masked_cleared", `FIM_OFF_MIS, 32'h0);
    wait_irq(1'b0);
    wr(`FIM_OFF_EN, 32'h0);
  endtask : t_single_event

  task automatic t_both_events;
    wr(`FIM_OFF_EN, 32'h3);
    pulse(2'h3);
    rd_chk("masked_both", `FIM_OFF_MIS, 32'h3);
    wait_irq(1'b1);
    wr(`FIM_OFF_MIS, 32'h2);
    rd_chk("masked_left", `FIM_OFF_MIS, 32'h1);
    repeat (3) @(posedge clk_sys);
    #1;
    chk("irq_or", 32'h1, {31'h0, flash_irq});
    wr(`FIM_OFF_MIS, 32'h1);
    rd_chk("raw_none", `FIM_OFF_RAW, 32'h0);
    wait_irq(1'b0);
    chk("irq_entries", 32'h3, {24'h0, irq_entries});
  endtask : t_both_events

  task automatic t_set_wins;
    @(posedge clk_sys);
    program_done_evt <= 1'b1;
    access_fault_evt <= 1'b1;
    reg_addr <= `FIM_OFF_MIS;
    reg_wdata <= 32'h3;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    program_done_evt <= 1'b0;
    access_fault_evt <= 1'b0;
    reg_wr <= 1'b0;
    rd_chk("set_wins", `FIM_OFF_RAW, 32'h3);
    wr(`FIM_OFF_MIS, 32'h3);
    rd_chk("raw_after_clear", `FIM_OFF_RAW, 32'h0);
    wait_irq(1'b0);
  endtask : t_set_wins

  task automatic t_back_to_back;
    @(posedge clk_sys);
    reg_addr <= `FIM_OFF_EN;
    reg_wdata <= 32'h2;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("b2b_enable", 32'h2, reg_rdata);
    @(posedge clk_sys);
    #1;
    chk("rdata_gone", 32'h0, reg_rdata);
    wr(`FIM_OFF_EN, 32'h0);
  endtask : t_back_to_back

  task automatic t_mid_reset;
    wr(`FIM_OFF_EN, 32'h3);
    pulse(2'h2);
    wait_irq(1'b1);
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("irq_in_reset", 32'h0, {31'h0, flash_irq});
    @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd_chk("enable_after_reset", `FIM_OFF_EN, 32'h0);
    rd_chk("raw_after_reset", `FIM_OFF_RAW, 32'h0);
    chk("irq_after_reset", 32'h0, {31'h0, flash_irq});
  endtask : t_mid_reset

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset_and_reserved();
    for (int k = 0; k < 2; k++) begin
      t_single_event(k);
    end
    t_both_events();
    t_set_wins();
    t_back_to_back();
    t_mid_reset();
    close_out();
  end
endmodule : tb_top
`default_nettype wire
